// ---- shared/ior_defines.svh ----
// Register offsets, field positions, reset values and timing counts for the readout block
`ifndef IOR_DEFINES_SVH
`define IOR_DEFINES_SVH

`define IOR_ADDR_W 8
// Register indices; the bus byte address is four times the index
`define IOR_IDX_STATUS 8'h1E
`define IOR_IDX_CTRL1_ACC 8'h10
`define IOR_IDX_CTRL2_GYR 8'h11
`define IOR_IDX_CTRL3 8'h12
`define IOR_IDX_CTRL4 8'h13
`define IOR_IDX_CTRL7_GYR 8'h16
`define IOR_IDX_ACC_AXES 8'h18
`define IOR_IDX_GYR_AXES 8'h19
`define IOR_IDX_PIN1 8'h0D
`define IOR_IDX_PIN2 8'h0E
`define IOR_IDX_GYR_OUT 8'h22
`define IOR_IDX_ACC_OUT 8'h28
`define IOR_IDX_SAMPLE 8'h40
`define IOR_IDX_BOOT 8'h41
// Field positions
`define IOR_BIT_ACC_NEW 0
`define IOR_BIT_GYR_NEW 1
`define IOR_BIT_LOCK 6
`define IOR_BIT_MASK 3
`define IOR_BIT_HP_EN 6
`define IOR_BIT_HP_RST 3
`define IOR_BIT_HP_CF 4
`define IOR_BIT_PIN_ACC 0
`define IOR_BIT_PIN_GYR 1
`define IOR_BIT_HP_MODE 4
// Reset values
`define IOR_RST_AXES 8'h38
`define IOR_RST_BYTE 8'h00
// Timing
`define IOR_CLK_MHZ 125
`define IOR_BOOT_MS 20
`define IOR_BOOT_CYC (`IOR_BOOT_MS * 1000 * `IOR_CLK_MHZ)
`define IOR_PD_ENTRY_US 1
`define IOR_PD_ENTRY_CYC (`IOR_PD_ENTRY_US * `IOR_CLK_MHZ)
`define IOR_GYR_ON_MS 80
`define IOR_GYR_ON_CYC (`IOR_GYR_ON_MS * 1000 * `IOR_CLK_MHZ)
`define IOR_AXI_OKAY 2'h0
`define IOR_AXI_SLVERR 2'h2

`endif

// ---- shared/ior_pkg.sv ----
// Types shared by the readout block
package ior_pkg;
   typedef enum logic [2:0] {
      IOR_BOOTING = 3'b001,
      IOR_POWERUP = 3'b010,
      IOR_RUN = 3'b100
   } ior_gyr_state_e;

   typedef struct packed {
      logic [15:0] x;
      logic [15:0] y;
      logic [15:0] z;
   } ior_triple_s;

   typedef struct packed {
      logic accReady;
      logic gyrReady;
   } ior_pins_s;
endpackage

// ---- hdl/ior_readout_ctrl.sv ----
// Inertial sample readout control: filter control, settling mask, status and data-ready
//
// Notes on behaviour
// [R1] Gyro high-pass enable applies filter to output registers and stored samples.
// [R2] Two-bit cutoff field selects one of four high-pass cutoffs.
// [R3] Writing high-pass reset clears DC from the next generated gyro sample.
// [R4] High-pass reset bit clears itself after the reset is done.
// [R5] Gyro low-pass cutoff follows output rate and power mode.
// [R6] Gyro wake from power-down within 80 ms; power-down entry within 1 us.
// [R7] First 2, 3 or 4 gyro samples after rate change or sleep exit invalid.
// [R8] Accel high-performance discards 1 to 112 settling samples by rate and bandwidth.
// [R9] Accel low-power and normal modes deliver a valid first sample.
// [R10] Mask control holds data-ready low until filters have settled.
// [R11] After boot of about 20 ms both sensors sit in power-down.
// [R12] Host activates accel with a mode and at least one axis.
// [R13] Host may write 38h, 60h, 01h to start the accelerometer.
// [R14] Host may write 38h, 60h, 02h to start the gyroscope.
// [R15] New-data flags set when a fresh sample set is available.
// [R16] Polling host reads status, then low then high byte per axis.
// [R17] Data-ready routes to pin one or pin two by routing controls.
// [R18] Data-ready rises once a new sample set is readable.
// [R19] Reading a high byte of an enabled channel clears data-ready.
// [R20] With lock set, a started byte pair is frozen until both bytes read.
// [R21] Slow unsynchronised hosts should enable the block update lock.
// [R22] Lock keeps only byte pairs coherent, not axes from one sample.
// [R23] Mask counts samples at current rate, releases on first after discard count.
//
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/100ps
`include "ior_defines.svh"

module ior_readout_ctrl #(
   parameter int BOOT_CYC = `IOR_BOOT_CYC,
   parameter int GYR_ON_CYC = `IOR_GYR_ON_CYC
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sampleClk,
   input wire ior_pkg::ior_triple_s accIn,
   input wire ior_pkg::ior_triple_s gyrIn,
   output ior_pkg::ior_pins_s interruptPinOne,
   output ior_pkg::ior_pins_s interruptPinTwo,
   output logic gyroHighpassActive,
   output logic gyroHighpassReset,
   output logic [1:0] gyroHighpassCutoffSel,
   output logic [3:0] gyroLowpassRateSel,
   output logic gyroHighPerf,
   output logic accPowered,
   output logic gyrPowered
);
   import ior_pkg::*;

   // ==========================================
   // Helpers
   function automatic logic [7:0] settleCount(input logic [3:0] rate, input logic hp,
                                              input logic [1:0] bw, input logic isGyr);
      logic [7:0] n;
      n = 8'h00;
      if (isGyr) begin
         n = (rate == 4'h7) ? 8'h03 : (rate == 4'h8) ? 8'h04 : 8'h02; // R7
      end else if (hp) begin
         case (rate)
            4'h4: n = (bw == 2'h3) ? 8'h02 : 8'h01;
            4'h5: n = (bw == 2'h3) ? 8'h04 : (bw == 2'h2) ? 8'h02 : 8'h01;
            4'h6: n = (bw == 2'h3) ? 8'h07 : (bw == 2'h2) ? 8'h03 : (bw == 2'h1) ? 8'h02 : 8'h01;
            4'h7: n = (bw == 2'h3) ? 8'h0E : (bw == 2'h2) ? 8'h07 : (bw == 2'h1) ? 8'h04 : 8'h02;
            4'h8: n = (bw == 2'h3) ? 8'h1C : (bw == 2'h2) ? 8'h0E : (bw == 2'h1) ? 8'h08 : 8'h04;
            4'h9: n = (bw == 2'h3) ? 8'h38 : (bw == 2'h2) ? 8'h1C : (bw == 2'h1) ? 8'h10 : 8'h08;
            4'hA: n = (bw == 2'h3) ? 8'h70 : (bw == 2'h2) ? 8'h38 : (bw == 2'h1) ? 8'h20 : 8'h10;
            default: n = 8'h01;
         endcase // R8
      end
      return n; // R9
   endfunction

   // ==========================================
   // Sample clock edge detect
   logic [2:0] smpSync;
   wire smpEdge = smpSync[1] & ~smpSync[2];
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) smpSync <= 3'h0;
      else smpSync <= {smpSync[1:0], sampleClk};
   end

   // ==========================================
   // Registers
   logic [7:0] accMode, gyrMode, ctrl3, ctrl4, ctrl7, accAxes, gyrAxes, pin1, pin2;
   logic [7:0] ctrl6Bw;
   logic [31:0] bootCnt, gyrOnCnt;
   ior_gyr_state_e gyrState;
   logic booted;
   ior_triple_s accOut, gyrOut;
   logic [2:0] accHold, gyrHold;
   logic accNew, gyrNew;
   logic [7:0] accSettle, gyrSettle;
   logic hpRstPend;

   wire accActive = booted && accMode[7:4] != 4'h0 && accAxes[5:3] != 3'h0; // R12
   wire gyrActive = (gyrState == IOR_RUN) && gyrMode[7:4] != 4'h0 && gyrAxes[5:3] != 3'h0;
   wire lockOn = ctrl3[`IOR_BIT_LOCK];
   wire maskOn = ctrl4[`IOR_BIT_MASK];

   // ==========================================
   // AXI4-Lite write
   logic awHeld, wHeld;
   logic [7:0] awAddr;
   logic [31:0] wData;
   logic [3:0] wStrb;
   wire doWrite = awHeld && wHeld && !s_axi_bvalid;
   wire [7:0] wIdx = awAddr >> 2;
   wire wOk = wIdx == `IOR_IDX_CTRL1_ACC || wIdx == `IOR_IDX_CTRL2_GYR || wIdx == `IOR_IDX_CTRL3
      || wIdx == `IOR_IDX_CTRL4 || wIdx == `IOR_IDX_CTRL7_GYR || wIdx == `IOR_IDX_ACC_AXES
      || wIdx == `IOR_IDX_GYR_AXES || wIdx == `IOR_IDX_PIN1 || wIdx == `IOR_IDX_PIN2;
   wire wEn = doWrite && wOk && wStrb[0];
   wire [7:0] wb = wData[7:0];
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awHeld <= 1'b0;
         wHeld <= 1'b0;
         awAddr <= 8'h00;
         wData <= 32'h0;
         wStrb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `IOR_AXI_OKAY;
      end else begin
         s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
         s_axi_wready <= !wHeld && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         if (doWrite) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wOk ? `IOR_AXI_OKAY : `IOR_AXI_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ==========================================
   // AXI4-Lite read
   wire [7:0] rIdx = s_axi_araddr >> 2;
   wire rTake = s_axi_arvalid && s_axi_arready;
   wire rdGyrHi = rTake && (rIdx == 8'h23 || rIdx == 8'h25 || rIdx == 8'h27);
   wire rdAccHi = rTake && (rIdx == 8'h29 || rIdx == 8'h2B || rIdx == 8'h2D);
   wire [47:0] gyrFlat = gyrOut;
   wire [47:0] accFlat = accOut;
   wire [7:0] gOff = rIdx - `IOR_IDX_GYR_OUT;
   wire [7:0] aOff = rIdx - `IOR_IDX_ACC_OUT;
   wire [7:0] gByte = gyrFlat[47 - 8 * ((gOff ^ 8'h01) + 8'h00) -: 8];
   wire [7:0] aByte = accFlat[47 - 8 * ((aOff ^ 8'h01) + 8'h00) -: 8];
   wire [7:0] statusByte = {6'h00, gyrNew, accNew}; // R15
   logic [7:0] rByte;
   logic rOk;
   always_comb begin
      rOk = 1'b1;
      rByte = 8'h00;
      if (rIdx == `IOR_IDX_STATUS) rByte = statusByte;
      else if (rIdx == `IOR_IDX_CTRL1_ACC) rByte = accMode;
      else if (rIdx == `IOR_IDX_CTRL2_GYR) rByte = gyrMode;
      else if (rIdx == `IOR_IDX_CTRL3) rByte = ctrl3;
      else if (rIdx == `IOR_IDX_CTRL4) rByte = ctrl4;
      else if (rIdx == `IOR_IDX_CTRL7_GYR) rByte = ctrl7;
      else if (rIdx == `IOR_IDX_ACC_AXES) rByte = accAxes;
      else if (rIdx == `IOR_IDX_GYR_AXES) rByte = gyrAxes;
      else if (rIdx == `IOR_IDX_PIN1) rByte = pin1;
      else if (rIdx == `IOR_IDX_PIN2) rByte = pin2;
      else if (rIdx >= 8'h22 && rIdx <= 8'h27) rByte = gByte;
      else if (rIdx >= 8'h28 && rIdx <= 8'h2D) rByte = aByte;
      else if (rIdx == `IOR_IDX_SAMPLE) rByte = ctrl6Bw;
      else if (rIdx == `IOR_IDX_BOOT) rByte = {5'h00, gyrState};
      else rOk = 1'b0;
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= `IOR_AXI_OKAY;
      end else begin
         s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
         if (rTake) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h0, rByte};
            s_axi_rresp <= rOk ? `IOR_AXI_OKAY : `IOR_AXI_SLVERR;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ==========================================
   // Control registers, boot and gyro power sequence
   wire hpRstDone = hpRstPend && smpEdge && gyrActive;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         {accMode, gyrMode, ctrl3, ctrl4, pin1, pin2, ctrl6Bw} <= {7{`IOR_RST_BYTE}};
         ctrl7 <= `IOR_RST_BYTE;
         accAxes <= `IOR_RST_AXES;
         gyrAxes <= `IOR_RST_AXES;
         hpRstPend <= 1'b0;
      end else begin
         if (wEn && wIdx == `IOR_IDX_CTRL1_ACC) accMode <= wb;
         if (wEn && wIdx == `IOR_IDX_CTRL2_GYR) gyrMode <= wb;
         if (wEn && wIdx == `IOR_IDX_CTRL3) ctrl3 <= wb;
         if (wEn && wIdx == `IOR_IDX_CTRL4) ctrl4 <= wb;
         if (wEn && wIdx == `IOR_IDX_ACC_AXES) accAxes <= wb;
         if (wEn && wIdx == `IOR_IDX_GYR_AXES) gyrAxes <= wb;
         if (wEn && wIdx == `IOR_IDX_PIN1) pin1 <= wb;
         if (wEn && wIdx == `IOR_IDX_PIN2) pin2 <= wb;
         if (wEn && wIdx == `IOR_IDX_CTRL7_GYR) begin
            ctrl7 <= wb;
            hpRstPend <= wb[`IOR_BIT_HP_RST]; // R3
         end else if (hpRstDone) begin
            ctrl7[`IOR_BIT_HP_RST] <= 1'b0; // R4
            hpRstPend <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bootCnt <= 32'h0;
         booted <= 1'b0;
         gyrOnCnt <= 32'h0;
         gyrState <= IOR_BOOTING;
      end else begin
         case (gyrState)
            IOR_BOOTING: begin
               bootCnt <= bootCnt + 32'h1;
               if (bootCnt == 32'(BOOT_CYC - 1)) begin
                  booted <= 1'b1; // R11
                  gyrState <= IOR_POWERUP;
                  gyrOnCnt <= 32'h0;
               end
            end
            IOR_POWERUP: begin
               if (gyrMode[7:4] == 4'h0) gyrOnCnt <= 32'h0;
               else gyrOnCnt <= gyrOnCnt + 32'h1;
               if (gyrOnCnt == 32'(GYR_ON_CYC - 1)) gyrState <= IOR_RUN; // R6
            end
            IOR_RUN: begin
               if (gyrMode[7:4] == 4'h0) begin
                  gyrState <= IOR_POWERUP; // R6
                  gyrOnCnt <= 32'h0;
               end
            end
            default: gyrState <= IOR_BOOTING;
         endcase
      end
   end

   // ==========================================
   // Sample capture, lock, settling and flags
   wire [7:0] accNeed = settleCount(accMode[7:4], !ctrl6Bw[`IOR_BIT_HP_MODE] &&
      accMode[7:4] >= 4'h1, accMode[1:0], 1'b0);
   wire [7:0] gyrNeed = settleCount(gyrMode[7:4], 1'b1, 2'h0, 1'b1);
   wire accCfgWr = wEn && (wIdx == `IOR_IDX_CTRL1_ACC || wIdx == `IOR_IDX_CTRL4);
   wire gyrCfgWr = wEn && (wIdx == `IOR_IDX_CTRL2_GYR || wIdx == `IOR_IDX_CTRL4);
   wire accSmp = smpEdge && accActive;
   wire gyrSmp = smpEdge && gyrActive;
   wire accSettled = !maskOn || accSettle >= accNeed; // R10
   wire gyrSettled = !maskOn || gyrSettle >= gyrNeed;
   wire [2:0] accRdLo = {3{rTake}} & {rIdx == 8'h2C, rIdx == 8'h2A, rIdx == 8'h28};
   wire [2:0] accRdHi = {3{rTake}} & {rIdx == 8'h2D, rIdx == 8'h2B, rIdx == 8'h29};
   wire [2:0] gyrRdLo = {3{rTake}} & {rIdx == 8'h26, rIdx == 8'h24, rIdx == 8'h22};
   wire [2:0] gyrRdHi = {3{rTake}} & {rIdx == 8'h27, rIdx == 8'h25, rIdx == 8'h23};
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         accOut <= '0;
         gyrOut <= '0;
         accHold <= 3'h0;
         gyrHold <= 3'h0;
         accNew <= 1'b0;
         gyrNew <= 1'b0;
         accSettle <= 8'h00;
         gyrSettle <= 8'h00;
      end else begin
         // Lock holds a pair from its first byte read until its second
         accHold <= lockOn ? (accHold ^ (accRdLo | accRdHi)) : 3'h0; // R20 R22
         gyrHold <= lockOn ? (gyrHold ^ (gyrRdLo | gyrRdHi)) : 3'h0; // R20 R22
         if (accCfgWr) accSettle <= 8'h00; // R23
         else if (accSmp && accSettle != 8'hFF) accSettle <= accSettle + 8'h01;
         if (gyrCfgWr) gyrSettle <= 8'h00; // R7 R23
         else if (gyrSmp && gyrSettle != 8'hFF) gyrSettle <= gyrSettle + 8'h01;
         if (accSmp) begin
            if (!accHold[0]) accOut.x <= accIn.x;
            if (!accHold[1]) accOut.y <= accIn.y;
            if (!accHold[2]) accOut.z <= accIn.z;
         end
         if (gyrSmp) begin
            if (!gyrHold[0]) gyrOut.x <= gyrIn.x;
            if (!gyrHold[1]) gyrOut.y <= gyrIn.y;
            if (!gyrHold[2]) gyrOut.z <= gyrIn.z;
         end
         if (accSmp && accSettled) accNew <= 1'b1; // R15 R18
         else if (rdAccHi) accNew <= 1'b0; // R19
         if (gyrSmp && gyrSettled) gyrNew <= 1'b1; // R15 R18
         else if (rdGyrHi) gyrNew <= 1'b0; // R19
      end
   end

   // ==========================================
   // Pins and filter control outputs
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         interruptPinOne <= '0;
         interruptPinTwo <= '0;
         gyroHighpassActive <= 1'b0;
         gyroHighpassReset <= 1'b0;
         gyroHighpassCutoffSel <= 2'h0;
         gyroLowpassRateSel <= 4'h0;
         gyroHighPerf <= 1'b0;
         accPowered <= 1'b0;
         gyrPowered <= 1'b0;
      end else begin
         interruptPinOne.accReady <= accNew && pin1[`IOR_BIT_PIN_ACC]; // R17
         interruptPinOne.gyrReady <= gyrNew && pin1[`IOR_BIT_PIN_GYR]; // R17
         interruptPinTwo.accReady <= accNew && pin2[`IOR_BIT_PIN_ACC]; // R17
         interruptPinTwo.gyrReady <= gyrNew && pin2[`IOR_BIT_PIN_GYR]; // R17
         gyroHighpassActive <= ctrl7[`IOR_BIT_HP_EN]; // R1
         gyroHighpassReset <= hpRstDone; // R3
         gyroHighpassCutoffSel <= ctrl7[`IOR_BIT_HP_CF +: 2]; // R2
         gyroLowpassRateSel <= gyrMode[7:4]; // R5
         gyroHighPerf <= !ctrl6Bw[`IOR_BIT_HP_MODE]; // R5
         accPowered <= accActive;
         gyrPowered <= gyrState == IOR_RUN && gyrMode[7:4] != 4'h0;
      end
   end

   // ==========================================
   // Checks
   property p_hpclear;
      @(posedge clk) disable iff (!rst_n) hpRstDone && !wEn |=> !ctrl7[`IOR_BIT_HP_RST];
   endproperty
   a_hpclear: assert property (p_hpclear) else $error("hp reset bit stuck"); // R4
   property p_clrhi;
      @(posedge clk) disable iff (!rst_n) rdAccHi && !accSmp |=> !accNew;
   endproperty
   a_clrhi: assert property (p_clrhi) else $error("accel ready not cleared"); // R19
   property p_mask;
      @(posedge clk) disable iff (!rst_n) maskOn && gyrCfgWr ##1 !gyrSmp |=> !$rose(gyrNew);
   endproperty
   a_mask: assert property (p_mask) else $error("gyro ready during settle"); // R10
   property p_pin;
      @(posedge clk) disable iff (!rst_n) accNew && pin1[0] ##1 accNew && pin1[0]
         |-> interruptPinOne.accReady;
   endproperty
   a_pin: assert property (p_pin) else $error("pin one not routed"); // R17
   property p_boot;
      @(posedge clk) disable iff (!rst_n) !booted |-> !accNew && !gyrNew;
   endproperty
   a_boot: assert property (p_boot) else $error("data before boot"); // R11
   property p_set;
      @(posedge clk) disable iff (!rst_n) accSmp && accSettled |=> accNew;
   endproperty
   a_set: assert property (p_set) else $error("accel flag not set"); // R15
   property p_lock;
      @(posedge clk) disable iff (!rst_n) lockOn && accHold[0] && accSmp |=> $stable(accOut.x);
   endproperty
   a_lock: assert property (p_lock) else $error("locked pair refreshed"); // R20
   property p_gyrset;
      @(posedge clk) disable iff (!rst_n) gyrSmp && gyrSettled |=> gyrNew;
   endproperty
   a_gyrset: assert property (p_gyrset) else $error("gyro flag not set"); // R18
endmodule

// ---- testbench/ior_sensor_model.sv ----
// Sensor front end model: free-running sample clock and counting sample words
`timescale 1ns/100ps
module ior_sensor_model (
   output logic sampleClk,
   output ior_pkg::ior_triple_s accIn,
   output ior_pkg::ior_triple_s gyrIn
);
   import ior_pkg::*;
   // ======================================================================
   // Sample generation
   logic [7:0] count;
   initial begin
      sampleClk = 1'b0;
      count = 8'h00;
   end
   always #32 sampleClk = ~sampleClk;
   // Data moves away from the sampling edge; both bytes carry the count so a torn pair shows
   always @(negedge sampleClk) count <= count + 8'h01;
   assign accIn = {count, count, count, count, count, count};
   assign gyrIn = {count, count, count, count, count, count};
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking bench for the inertial readout control block
`timescale 1ns/100ps
`include "ior_defines.svh"
module tb_top;
   import ior_pkg::*;
   logic clk, rst_n, awValid, awReady, wValid, wReady, bValid, bReady;
   logic arValid, arReady, rValid, rReady, sampleClk;
   logic hpActive, hpReset, highPerf, accPowered, gyrPowered;
   logic [7:0] awAddr, arAddr;
   logic [31:0] wData, rData;
   logic [3:0] wStrb, lpRate;
   logic [1:0] bResp, rResp, hpCutoff;
   ior_triple_s accIn, gyrIn;
   ior_pins_s pinOne, pinTwo;
   int miscompares;
   int compares;
   // ======================================================================
   // Design, far side and clock
   ior_readout_ctrl #(.BOOT_CYC(20), .GYR_ON_CYC(20)) i_dut (
      .clk(clk), .rst_n(rst_n),
      .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
      .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
      .s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
      .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
      .sampleClk(sampleClk), .accIn(accIn), .gyrIn(gyrIn),
      .interruptPinOne(pinOne), .interruptPinTwo(pinTwo),
      .gyroHighpassActive(hpActive), .gyroHighpassReset(hpReset),
      .gyroHighpassCutoffSel(hpCutoff), .gyroLowpassRateSel(lpRate),
      .gyroHighPerf(highPerf), .accPowered(accPowered), .gyrPowered(gyrPowered)
   );
   ior_sensor_model i_sensor (.sampleClk(sampleClk), .accIn(accIn), .gyrIn(gyrIn));
   always #4 clk = ~clk;
   // ======================================================================
   // Bus cycles and comparison
   task automatic axiWrite(input logic [7:0] idx, input logic [7:0] val);
      int n;
      @(posedge clk);
      awAddr <= {idx[5:0], 2'b00};
      wData <= {24'h000000, val};
      awValid <= 1'b1;
      wValid <= 1'b1;
      bReady <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (awReady) awValid <= 1'b0;
         if (wReady) wValid <= 1'b0;
         if (bValid) break;
      end
      bReady <= 1'b0;
   endtask
   task automatic axiRead(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge clk);
      arAddr <= {idx[5:0], 2'b00};
      arValid <= 1'b1;
      rReady <= 1'b1;
      for (n = 0; n < 100; n++) begin
         @(posedge clk);
         if (arReady) arValid <= 1'b0;
         if (rValid) break;
      end
      d = rData;
      r = rResp;
      rReady <= 1'b0;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // ======================================================================
   // Scenarios
   task automatic chkBoot();
      logic [31:0] d;
      logic [1:0] r;
      check("acc powered", 32'h0, {31'h0, accPowered});
      check("gyr powered", 32'h0, {31'h0, gyrPowered});
      axiRead(`IOR_IDX_ACC_AXES, d, r);
      check("acc axes reset", 32'h38, d);
      axiRead(8'h01, d, r);
      check("unmapped resp", {30'h0, `IOR_AXI_SLVERR}, {30'h0, r});
   endtask
   task automatic chkAccReady();
      logic [31:0] d;
      logic [1:0] r;
      int n;
      axiWrite(`IOR_IDX_ACC_AXES, 8'h38);
      axiWrite(`IOR_IDX_CTRL1_ACC, 8'h60);
      axiWrite(`IOR_IDX_PIN1, 8'h01);
      for (n = 0; n < 300 && pinOne.accReady !== 1'b1; n++) @(posedge clk);
      check("pin one acc", 32'h1, {31'h0, pinOne.accReady});
      axiRead(8'h29, d, r);
      repeat (2) @(posedge clk);
      check("pin one acc cleared", 32'h0, {31'h0, pinOne.accReady});
      for (n = 0; n < 300 && pinOne.accReady !== 1'b1; n++) @(posedge clk);
      axiRead(`IOR_IDX_STATUS, d, r);
      check("acc new flag", 32'h1, {31'h0, d[`IOR_BIT_ACC_NEW]});
      axiWrite(`IOR_IDX_PIN1, 8'h00);
      axiWrite(`IOR_IDX_PIN2, 8'h01);
      for (n = 0; n < 300 && pinTwo.accReady !== 1'b1; n++) @(posedge clk);
      check("pin two acc", 32'h1, {31'h0, pinTwo.accReady});
      check("pin one acc unrouted", 32'h0, {31'h0, pinOne.accReady});
   endtask
   task automatic chkGyro();
      logic [31:0] d;
      logic [1:0] r;
      int n;
      int c;
      axiWrite(`IOR_IDX_GYR_AXES, 8'h38);
      axiWrite(`IOR_IDX_CTRL2_GYR, 8'h60);
      @(posedge clk);
      check("lowpass rate", 32'h6, {28'h0, lpRate});
      for (n = 0; n < 200 && gyrPowered !== 1'b1; n++) @(posedge clk);
      check("gyr powered up", 32'h1, {31'h0, gyrPowered});
      for (c = 0; c < 4; c++) begin
         axiWrite(`IOR_IDX_CTRL7_GYR, 8'h40 | (c[7:0] << 4));
         @(posedge clk);
         check("hp active", 32'h1, {31'h0, hpActive});
         check("hp cutoff", c, {30'h0, hpCutoff});
      end
      axiWrite(`IOR_IDX_CTRL7_GYR, 8'h78);
      for (n = 0; n < 100 && hpReset !== 1'b1; n++) @(posedge clk);
      check("hp reset pulse", 32'h1, {31'h0, hpReset});
      repeat (2) @(posedge clk);
      axiRead(`IOR_IDX_CTRL7_GYR, d, r);
      check("hp reset self clear", 32'h70, {24'h0, d[7:0]});
   endtask
   task automatic chkMask();
      logic [31:0] d;
      logic [1:0] r;
      logic last;
      int n;
      int e;
      axiWrite(`IOR_IDX_CTRL4, 8'h08);
      axiWrite(`IOR_IDX_PIN2, 8'h00);
      axiWrite(`IOR_IDX_PIN1, 8'h02);
      axiWrite(`IOR_IDX_CTRL2_GYR, 8'h70);
      axiRead(8'h23, d, r);
      // Let the cleared flag reach the registered pin before watching it
      repeat (2) @(posedge clk);
      e = 0;
      last = sampleClk;
      for (n = 0; n < 400 && pinOne.gyrReady !== 1'b1; n++) begin
         @(posedge clk);
         if (sampleClk && !last) e++;
         last = sampleClk;
      end
      check("gyr ready after settle", 32'h1, {31'h0, pinOne.gyrReady});
      check("settle edges at least 3", 32'h1, {31'h0, e >= 3});
   endtask
   task automatic chkLockAndOff();
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] lo;
      int n;
      axiWrite(`IOR_IDX_CTRL3, 8'h40);
      axiRead(8'h28, d, r);
      lo = d[7:0];
      repeat (40) @(posedge clk);
      axiRead(8'h29, d, r);
      check("pair coherent", {24'h0, lo}, {24'h0, d[7:0]});
      axiWrite(`IOR_IDX_CTRL2_GYR, 8'h00);
      for (n = 0; n < 125 && gyrPowered !== 1'b0; n++) @(posedge clk);
      check("gyr powered down", 32'h0, {31'h0, gyrPowered});
   endtask
   task automatic report_and_stop();
      if (miscompares == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   initial begin
      clk = 1'b0;
      rst_n = 1'b0;
      {awValid, wValid, bReady, arValid, rReady} = 5'h00;
      awAddr = 8'h00;
      arAddr = 8'h00;
      wData = 32'h0;
      wStrb = 4'hF;
      miscompares = 0;
      compares = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (30) @(posedge clk);
      chkBoot();
      chkAccReady();
      chkGyro();
      chkMask();
      chkLockAndOff();
      report_and_stop();
   end
   initial begin
      #200000;
      miscompares++;
      report_and_stop();
   end
endmodule
